//--- rtl/cio_pkg.sv
// Package: register map, field codes, reset values and timing constants for the camera IO block
package cio_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_LINE_PICK = 8'h00;
	localparam logic [7:0] OFS_LINE_DIRECTION = 8'h04;
	localparam logic [7:0] OFS_LINE_POLARITY_FLIP = 8'h08;
	localparam logic [7:0] OFS_LINE_LEVEL = 8'h0C;
	localparam logic [7:0] OFS_OUTPUT_SIGNAL_CHOICE = 8'h10;
	localparam logic [7:0] OFS_LINE_ELECTRICAL_KIND = 8'h14;
	localparam logic [7:0] OFS_FLASH_A_ORIGIN = 8'h18;
	localparam logic [7:0] OFS_FLASH_A_ON = 8'h1C;
	localparam logic [7:0] OFS_FLASH_A_LENGTH_US = 8'h20;
	localparam logic [7:0] OFS_FLASH_A_OFFSET_US = 8'h24;
	localparam logic [7:0] OFS_FLASH_B_ORIGIN = 8'h28;
	localparam logic [7:0] OFS_FLASH_B_ON = 8'h2C;
	localparam logic [7:0] OFS_FLASH_B_LENGTH_US = 8'h30;
	localparam logic [7:0] OFS_FLASH_B_OFFSET_US = 8'h34;
	localparam logic [7:0] OFS_FRAME_PERIOD_US = 8'h38;
	localparam logic [7:0] OFS_TRIG_WAIT_US = 8'h3C;

	// ==========================================
	// Line codes and field codes
	localparam logic [1:0] LINE_IN_A = 2'h0;
	localparam logic [1:0] LINE_IN_B = 2'h1;
	localparam logic [1:0] LINE_OUT_A = 2'h2;
	localparam logic [1:0] LINE_OUT_B = 2'h3;
	localparam logic [3:0] SRC_OFF = 4'h0;
	localparam logic [3:0] SRC_INT_BEGIN = 4'h1;
	localparam logic [3:0] SRC_INT_FINISH = 4'h2;
	localparam logic [3:0] SRC_INT_MID = 4'h3;
	localparam logic [3:0] SRC_INT_WINDOW = 4'h4;
	localparam logic [3:0] SRC_TRIG_DIRECT = 4'h5;
	localparam logic [3:0] SRC_TRIG_WAIT = 4'h6;
	localparam logic [3:0] SRC_WAVE = 4'h7;
	localparam logic [3:0] SRC_FLASH_A = 4'h8;
	localparam logic [3:0] SRC_FLASH_B = 4'h9;
	localparam logic [1:0] ORG_INT_BEGIN = 2'h0;
	localparam logic [1:0] ORG_READOUT = 2'h1;
	localparam logic [1:0] ORG_TRIGGER = 2'h2;
	localparam logic [1:0] KIND_UNATTACHED = 2'h0;
	localparam logic [1:0] KIND_HIGH_IMPEDANCE = 2'h1;
	localparam logic [1:0] KIND_TTL = 2'h2;
	localparam logic [1:0] KIND_ISOLATED = 2'h3;

	// ==========================================
	// Reset values and limits
	localparam logic [24:0] WIDTH_MIN_US = 25'h000_000A;
	localparam logic [24:0] TIME_MAX_US = 25'h0F4_2400;
	localparam logic [24:0] FLASH_LENGTH_RST = 25'h000_03E8;
	localparam logic [24:0] FLASH_OFFSET_RST = 25'h000_000A;
	localparam logic [24:0] FRAME_PERIOD_RST = 25'h0F4_2400;

	// ==========================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

endpackage

//--- rtl/cio_top.sv
// Camera digital IO line control and two strobe generators behind an APB slave
//
// Overview of operation
// - line_pick codes 0,1 pick the inputs, codes 2,3 pick the outputs
// - line_direction reads 0 for a picked input, 1 for a picked output
// - each of four lines has its own inversion bit, applied at the outputs and to input level reads but not to the trigger
// - line_level reads present logic level of the picked line
// - output source codes 0 to 9 in the fixed order listed
// - source is stored and driven only when the picked line is an output
// - line_electrical_kind reads the picked line's electrical format code
// - each strobe starts timing from integration begin, readout or trigger
// - strobe A pulses only while its enable holds 1
// - strobe B has its own independent enable
// - strobe width counted in microseconds, values below 10 raised to 10
// - width limited to frame period minus delay, written times saturate at 16 seconds
// - strobe starts after programmable microsecond delay, minimum zero
// - begin, finish and midpoint sources are single-cycle pulses
// - integration window source stays high for the whole exposure
// - trigger direct passes trigger at once, waited one after trigger delay
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps

module cio_top
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_in_line_a,
	input wire logic i_in_line_b,
	input wire logic i_integration_active,
	input wire logic i_readout_start,
	input wire logic i_wave,
	input wire logic [cio_pkg::TICK_LAST - cio_pkg::TICK_LAST + 1:0] i_unused_kind_dummy,
	output logic o_out_line_a,
	output logic o_out_line_b,
	output logic o_trigger_seen
);
	import cio_pkg::*;

	// ==========================================
	// State record
	typedef struct packed {
		logic [1:0] in_a_s1, in_a_s2, in_b_s1, in_b_s2;
		logic [1:0] pad_unused;
		logic [1:0] pick;
		logic [3:0] flip;
		logic [3:0] src_a, src_b;
		logic [1:0] org_a, org_b;
		logic on_a, on_b;
		logic [24:0] len_a, len_b, ofs_a, ofs_b, frame, trig_wait;
		logic [6:0] tick_cnt;
		logic tick;
		logic int_d;
		logic trig_d;
		logic rdout_d;
		logic [24:0] int_len, int_cnt;
		logic mid;
		logic [24:0] tw_cnt;
		logic tw_busy;
		logic [24:0] fa_cnt, fb_cnt;
		logic [1:0] fa_ph, fb_ph;
		logic out_a, out_b;
		logic [31:0] prdata;
		logic pready, pslverr;
		logic trig_seen;
	} cio_state_t;

	cio_state_t st_r, st_nxt;

	logic [3:0] raw_line;
	logic [3:0] lvl;
	logic int_begin, int_finish, trig_pulse, tw_pulse, rdout_pulse;
	logic [9:0] sig_vec;
	logic [24:0] ofs_cl_a, ofs_cl_b, len_cl_a, len_cl_b;

	// ==========================================
	// Helpers
	// Clamp width to [min, frame - delay]; delay first clamped to frame
	function automatic logic [24:0] clamp_len(input logic [24:0] len, input logic [24:0] ofs,
		input logic [24:0] frm);
		logic [24:0] room;
		room = frm - ofs;
		clamp_len = (len < WIDTH_MIN_US) ? WIDTH_MIN_US : len;
		if (clamp_len > room)
			clamp_len = room;
	endfunction

	function automatic logic [24:0] sat25(input logic [31:0] v);
		sat25 = (v > 32'(TIME_MAX_US)) ? TIME_MAX_US : v[24:0];
	endfunction

	// Event and signal decode, all from synchronised or registered values
	always_comb
	begin
		int_begin = st_r.in_a_s2[1] & ~st_r.int_d;
		int_finish = ~st_r.in_a_s2[1] & st_r.int_d;
		trig_pulse = st_r.in_b_s2[1] & ~st_r.trig_d;
		rdout_pulse = st_r.in_b_s2[0] & ~st_r.rdout_d;
		tw_pulse = st_r.tw_busy & st_r.tick & (st_r.tw_cnt == 25'h000_0000);
		raw_line = {st_r.out_b, st_r.out_a, st_r.in_b_s2[1], st_r.in_a_s2[0]};
		// Outputs already carry their flip, so only the inputs are inverted here
		lvl = raw_line ^ {2'b00, st_r.flip[1:0]};
		ofs_cl_a = (st_r.ofs_a > st_r.frame) ? st_r.frame : st_r.ofs_a;
		ofs_cl_b = (st_r.ofs_b > st_r.frame) ? st_r.frame : st_r.ofs_b;
		len_cl_a = clamp_len(st_r.len_a, ofs_cl_a, st_r.frame);
		len_cl_b = clamp_len(st_r.len_b, ofs_cl_b, st_r.frame);
		// Source table in code order
		sig_vec = {st_r.fb_ph == 2'h2, st_r.fa_ph == 2'h2, st_r.pad_unused[1],
			tw_pulse, trig_pulse, st_r.in_a_s2[1], st_r.mid, int_finish, int_begin,
			1'b0};
	end

	// Next state
	always_comb
	begin
		logic [1:0] fa_ref, fb_ref;
		logic wr, rd;
		fa_ref = 2'h0;
		fb_ref = 2'h0;
		wr = 1'b0;
		rd = 1'b0;
		st_nxt = st_r;
		// Two-stage synchronisers for pins, one register stage for the wave
		st_nxt.in_a_s1 = {i_integration_active, i_in_line_a};
		st_nxt.in_a_s2 = st_r.in_a_s1;
		st_nxt.in_b_s1 = {i_in_line_b, i_readout_start};
		st_nxt.in_b_s2 = st_r.in_b_s1;
		st_nxt.pad_unused = {i_wave, 1'b0};
		st_nxt.int_d = st_r.in_a_s2[1];
		st_nxt.trig_d = st_r.in_b_s2[1];
		st_nxt.rdout_d = st_r.in_b_s2[0];
		st_nxt.trig_seen = trig_pulse;
		// Microsecond tick
		st_nxt.tick = 1'b0;
		if (st_r.tick_cnt == TICK_LAST)
		begin
			st_nxt.tick_cnt = 7'h00;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.tick_cnt = st_r.tick_cnt + 7'h01;
		// Exposure length measure and midpoint pulse
		st_nxt.mid = 1'b0;
		if (int_begin)
			st_nxt.int_cnt = 25'h000_0000;
		else if (st_r.in_a_s2[1] && st_r.tick)
			st_nxt.int_cnt = st_r.int_cnt + 25'h000_0001;
		if (int_finish)
			st_nxt.int_len = st_r.int_cnt;
		if (st_r.in_a_s2[1] && st_r.tick && st_r.int_len != 25'h000_0000
			&& st_r.int_cnt == {1'b0, st_r.int_len[24:1]})
			st_nxt.mid = 1'b1;
		// Delayed trigger
		if (trig_pulse)
		begin
			st_nxt.tw_busy = 1'b1;
			st_nxt.tw_cnt = st_r.trig_wait;
		end
		else if (tw_pulse)
			st_nxt.tw_busy = 1'b0;
		else if (st_r.tw_busy && st_r.tick)
			st_nxt.tw_cnt = st_r.tw_cnt - 25'h000_0001;
		// Strobe reference pick
		case (st_r.org_a)
			ORG_INT_BEGIN: fa_ref = {1'b0, int_begin};
			ORG_READOUT: fa_ref = {1'b0, rdout_pulse};
			ORG_TRIGGER: fa_ref = {1'b0, trig_pulse};
			default: fa_ref = 2'h0;
		endcase
		case (st_r.org_b)
			ORG_INT_BEGIN: fb_ref = {1'b0, int_begin};
			ORG_READOUT: fb_ref = {1'b0, rdout_pulse};
			ORG_TRIGGER: fb_ref = {1'b0, trig_pulse};
			default: fb_ref = 2'h0;
		endcase
		// Strobe A: phase 0 idle, 1 delay, 2 pulse
		if (!st_r.on_a)
			st_nxt.fa_ph = 2'h0;
		else if (fa_ref[0])
		begin
			st_nxt.fa_ph = (ofs_cl_a == 25'h000_0000) ? 2'h2 : 2'h1;
			st_nxt.fa_cnt = (ofs_cl_a == 25'h000_0000) ? len_cl_a : ofs_cl_a;
		end
		else if (st_r.fa_ph != 2'h0 && st_r.tick)
		begin
			if (st_r.fa_cnt <= 25'h000_0001)
			begin
				st_nxt.fa_ph = (st_r.fa_ph == 2'h1) ? 2'h2 : 2'h0;
				st_nxt.fa_cnt = len_cl_a;
			end
			else
				st_nxt.fa_cnt = st_r.fa_cnt - 25'h000_0001;
		end
		// Strobe B, same scheme with its own enable
		if (!st_r.on_b)
			st_nxt.fb_ph = 2'h0;
		else if (fb_ref[0])
		begin
			st_nxt.fb_ph = (ofs_cl_b == 25'h000_0000) ? 2'h2 : 2'h1;
			st_nxt.fb_cnt = (ofs_cl_b == 25'h000_0000) ? len_cl_b : ofs_cl_b;
		end
		else if (st_r.fb_ph != 2'h0 && st_r.tick)
		begin
			if (st_r.fb_cnt <= 25'h000_0001)
			begin
				st_nxt.fb_ph = (st_r.fb_ph == 2'h1) ? 2'h2 : 2'h0;
				st_nxt.fb_cnt = len_cl_b;
			end
			else
				st_nxt.fb_cnt = st_r.fb_cnt - 25'h000_0001;
		end
		// Output lines, polarity applied after source pick
		st_nxt.out_a = (st_r.src_a > SRC_FLASH_B ? 1'b0 : sig_vec[st_r.src_a]) ^ st_r.flip[2];
		st_nxt.out_b = (st_r.src_b > SRC_FLASH_B ? 1'b0 : sig_vec[st_r.src_b]) ^ st_r.flip[3];
		// APB: one wait state, answer in access phase
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		if (i_psel && i_penable && !st_r.pready)
		begin
			wr = i_pwrite;
			rd = !i_pwrite;
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0000_0000;
			case (i_paddr)
				OFS_LINE_PICK:
				begin
					if (wr)
						st_nxt.pick = i_pwdata[1:0];
					st_nxt.prdata = {30'h0000_0000, st_r.pick};
				end
				OFS_LINE_DIRECTION:
					st_nxt.prdata = {31'h0000_0000, st_r.pick[1]};
				OFS_LINE_POLARITY_FLIP:
				begin
					if (wr)
						st_nxt.flip[st_r.pick] = i_pwdata[0];
					st_nxt.prdata = {31'h0000_0000, st_r.flip[st_r.pick]};
				end
				OFS_LINE_LEVEL:
					st_nxt.prdata = {31'h0000_0000, lvl[st_r.pick]};
				OFS_OUTPUT_SIGNAL_CHOICE:
				begin
					if (wr && st_r.pick == LINE_OUT_A && i_pwdata <= 32'(SRC_FLASH_B))
						st_nxt.src_a = i_pwdata[3:0];
					if (wr && st_r.pick == LINE_OUT_B && i_pwdata <= 32'(SRC_FLASH_B))
						st_nxt.src_b = i_pwdata[3:0];
					if (wr && (!st_r.pick[1] || i_pwdata > 32'(SRC_FLASH_B)))
						st_nxt.pslverr = 1'b1;
					st_nxt.prdata = {28'h000_0000, st_r.pick == LINE_OUT_B ? st_r.src_b :
						st_r.pick == LINE_OUT_A ? st_r.src_a : SRC_OFF};
				end
				OFS_LINE_ELECTRICAL_KIND:
					st_nxt.prdata = {30'h0000_0000, st_r.pick[1] ? KIND_TTL : KIND_ISOLATED};
				OFS_FLASH_A_ORIGIN:
				begin
					if (wr && i_pwdata[1:0] != 2'h3)
						st_nxt.org_a = i_pwdata[1:0];
					st_nxt.prdata = {30'h0000_0000, st_r.org_a};
				end
				OFS_FLASH_A_ON:
				begin
					if (wr)
						st_nxt.on_a = i_pwdata[0];
					st_nxt.prdata = {31'h0000_0000, st_r.on_a};
				end
				OFS_FLASH_A_LENGTH_US:
				begin
					if (wr)
						st_nxt.len_a = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, len_cl_a};
				end
				OFS_FLASH_A_OFFSET_US:
				begin
					if (wr)
						st_nxt.ofs_a = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, ofs_cl_a};
				end
				OFS_FLASH_B_ORIGIN:
				begin
					if (wr && i_pwdata[1:0] != 2'h3)
						st_nxt.org_b = i_pwdata[1:0];
					st_nxt.prdata = {30'h0000_0000, st_r.org_b};
				end
				OFS_FLASH_B_ON:
				begin
					if (wr)
						st_nxt.on_b = i_pwdata[0];
					st_nxt.prdata = {31'h0000_0000, st_r.on_b};
				end
				OFS_FLASH_B_LENGTH_US:
				begin
					if (wr)
						st_nxt.len_b = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, len_cl_b};
				end
				OFS_FLASH_B_OFFSET_US:
				begin
					if (wr)
						st_nxt.ofs_b = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, ofs_cl_b};
				end
				OFS_FRAME_PERIOD_US:
				begin
					if (wr)
						st_nxt.frame = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, st_r.frame};
				end
				OFS_TRIG_WAIT_US:
				begin
					if (wr)
						st_nxt.trig_wait = sat25(i_pwdata);
					st_nxt.prdata = {7'h00, st_r.trig_wait};
				end
				default:
					st_nxt.pslverr = 1'b1;
			endcase
			if (rd)
				st_nxt.pslverr = st_nxt.pslverr & (i_paddr > OFS_TRIG_WAIT_US || i_paddr[1:0] != 2'h0);
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r <= '0;
			st_r.len_a <= FLASH_LENGTH_RST;
			st_r.len_b <= FLASH_LENGTH_RST;
			st_r.ofs_a <= FLASH_OFFSET_RST;
			st_r.ofs_b <= FLASH_OFFSET_RST;
			st_r.frame <= FRAME_PERIOD_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign o_prdata = st_r.prdata;
	assign o_pready = st_r.pready;
	assign o_pslverr = st_r.pslverr;
	assign o_out_line_a = st_r.out_a;
	assign o_out_line_b = st_r.out_b;
	assign o_trigger_seen = st_r.trig_seen;

	// ==========================================
	// Checks
	a_tick_period: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.tick |=> !st_r.tick [*8]) else $error("tick too frequent");
	a_flash_a_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!st_r.on_a |=> st_r.fa_ph == 2'h0) else $error("strobe A runs while off");
	a_flash_b_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!st_r.on_b |=> st_r.fb_ph == 2'h0) else $error("strobe B runs while off");
	a_dir_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_psel && i_penable && !st_r.pready && !i_pwrite && i_paddr == OFS_LINE_DIRECTION
		|=> o_prdata == {31'h0, $past(st_r.pick[1])}) else $error("direction wrong");
	a_src_guard: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!st_r.pick[1] |=> $stable(st_r.src_a) && $stable(st_r.src_b))
		else $error("source changed with input picked");
	a_len_min: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.frame >= 25'h000_0014 && ofs_cl_a <= 25'h000_000A |-> len_cl_a >= WIDTH_MIN_US)
		else $error("width below minimum");
	a_sum_fit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.frame >= WIDTH_MIN_US |-> 26'(ofs_cl_a) + 26'(len_cl_a) <= 26'(st_r.frame))
		else $error("delay plus width exceeds frame");
	a_mid_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.mid |=> !st_r.mid) else $error("midpoint not single");
	a_pready_one: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_pready |=> !o_pready) else $error("pready held");
	c_flash_a: cover property (@(posedge i_clk) st_r.fa_ph == 2'h2);
	c_flash_b: cover property (@(posedge i_clk) st_r.fb_ph == 2'h2);
	c_trig_wait: cover property (@(posedge i_clk) tw_pulse);
	c_mid: cover property (@(posedge i_clk) st_r.mid);

endmodule

//--- bench/cio_far_end.sv
// Far-side model: trigger source, sensor exposure, readout and wave source
`timescale 1ns/1ps

module cio_far_end
(
	input wire logic i_clk,
	output logic o_line_a,
	output logic o_line_b,
	output logic o_expose,
	output logic o_readout,
	output logic o_wave
);
	// ==========================================
	// Idle: lines low, no exposure under way
	initial
	begin
		o_line_a = 1'b0;
		o_line_b = 1'b0;
		o_expose = 1'b0;
		o_readout = 1'b0;
		o_wave = 1'b0;
	end

	// Static levels of the first line and the wave, changed after an edge
	task automatic set_lv(input logic a, input logic w);
		o_line_a <= a;
		o_wave <= w;
	endtask

	// Trigger pulse of n clocks on the second input line
	task automatic trig(input int n);
		o_line_b <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_line_b <= 1'b0;
	endtask

	// Exposure of n clocks, then readout of n clocks
	task automatic expose(input int n);
		o_expose <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_expose <= 1'b0;
		o_readout <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_readout <= 1'b0;
	endtask
endmodule

//--- bench/test_cio_top.sv
// Self-checking bench for the camera IO line and strobe block
`timescale 1ns/1ps

module test_cio_top;
	import cio_pkg::*;
	logic i_clk, i_nrst, i_psel, i_penable, i_pwrite;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic o_pready, o_pslverr, o_out_line_a, o_out_line_b;
	logic ln_a, ln_b, expo, rdo, wave;
	int fails, num_checks, cyc, seed, d, w;
	int m_pick;
	int m_src[4];
	logic [31:0] rd;
	logic er;
	logic trg;
	int n_trig;

	cio_top i_cio_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_in_line_a(ln_a), .i_in_line_b(ln_b),
		.i_integration_active(expo), .i_readout_start(rdo), .i_wave(wave),
		.i_unused_kind_dummy(2'h0), .o_out_line_a(o_out_line_a),
		.o_out_line_b(o_out_line_b), .o_trigger_seen(trg));
	cio_far_end i_cio_far_end (.i_clk(i_clk), .o_line_a(ln_a), .o_line_b(ln_b),
		.o_expose(expo), .o_readout(rdo), .o_wave(wave));

	// ==========================================
	// Clock, and a ceiling on the whole run
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fails++;
			stop_test();
		end
	end

	// Trigger pulses seen by the block, one per trigger edge expected
	always @(posedge i_clk)
	begin
		if (trg === 1'b1)
			n_trig <= n_trig + 1;
	end

	// ==========================================
	// Comparison, verdict and bus tasks
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Entered just after an edge; waits on pready, never on a fixed count
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
		int n;
		i_psel <= 1'b1;
		i_pwrite <= wr_en;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_pready !== 1'b1 && n < 50);
		rd = o_prdata;
		er = o_pslverr;
		check(n < 50, 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic e);
		apb(1'b1, a, wd);
		check(er, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		check(er, 1'b0);
		check(rd, x);
	endtask

	// Counts clocks to the rise of output line b, then its high time
	task automatic meas();
		d = 0;
		w = 0;
		while (o_out_line_b !== 1'b1 && d < 3000)
		begin
			@(posedge i_clk);
			d++;
		end
		while (o_out_line_b === 1'b1 && w < 3000)
		begin
			@(posedge i_clk);
			w++;
		end
	endtask

	// Counts high clocks of output line a over one exposure and its readout
	task automatic cnt_hi(input int n);
		w = 0;
		repeat (2 * n + 20)
		begin
			@(posedge i_clk);
			if (o_out_line_a === 1'b1)
				w++;
		end
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		fails = 0;
		num_checks = 0;
		cyc = 0;
		n_trig = 0;
		seed = 32'h2e2a;
		i_nrst = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		// Line codes, direction and electrical kind per line
		for (int p = 0; p < 4; p++)
		begin
			m_pick = p;
			wr(OFS_LINE_PICK, m_pick, 1'b0);
			rdc(OFS_LINE_PICK, m_pick);
			rdc(OFS_LINE_DIRECTION, m_pick >= 2);
			rdc(OFS_LINE_ELECTRICAL_KIND, (m_pick >= 2) ? KIND_TTL : KIND_ISOLATED);
		end
		// Every source code on an output, then an illegal one
		for (int c = 0; c < 10; c++)
		begin
			m_src[3] = c;
			wr(OFS_OUTPUT_SIGNAL_CHOICE, m_src[3], 1'b0);
			rdc(OFS_OUTPUT_SIGNAL_CHOICE, m_src[3]);
		end
		wr(OFS_OUTPUT_SIGNAL_CHOICE, 32'h0000_000A, 1'b1);
		rdc(OFS_OUTPUT_SIGNAL_CHOICE, m_src[3]);
		wr(OFS_LINE_PICK, LINE_IN_A, 1'b0);
		wr(OFS_OUTPUT_SIGNAL_CHOICE, SRC_TRIG_DIRECT, 1'b1);
		apb(1'b0, 8'h40, 32'h0000_0000);
		check(er, 1'b1);
		// Input level with and without inversion
		for (int k = 0; k < 4; k++)
		begin
			i_cio_far_end.set_lv(k[0], 1'b0);
			wr(OFS_LINE_POLARITY_FLIP, k[1], 1'b0);
			repeat (4) @(posedge i_clk);
			rdc(OFS_LINE_LEVEL, k[0] ^ k[1]);
		end
		// Exposure window on output a, then inverted
		wr(OFS_LINE_PICK, LINE_OUT_A, 1'b0);
		wr(OFS_OUTPUT_SIGNAL_CHOICE, SRC_INT_WINDOW, 1'b0);
		fork
			i_cio_far_end.expose(40);
			begin
				repeat (20) @(posedge i_clk);
				check(o_out_line_a, 1'b1);
				repeat (40) @(posedge i_clk);
				check(o_out_line_a, 1'b0);
			end
		join
		wr(OFS_LINE_POLARITY_FLIP, 32'h0000_0001, 1'b0);
		repeat (4) @(posedge i_clk);
		check(o_out_line_a, 1'b1);
		wr(OFS_LINE_POLARITY_FLIP, 32'h0000_0000, 1'b0);
		// Begin, finish and midpoint pulses; midpoint relies on the exposure measured before it
		for (int s = 1; s < 4; s++)
		begin
			wr(OFS_OUTPUT_SIGNAL_CHOICE, s, 1'b0);
			fork
				i_cio_far_end.expose(300);
				cnt_hi(300);
			join
			check(w, 32'h0000_0001);
		end
		// Random wave on output a
		wr(OFS_OUTPUT_SIGNAL_CHOICE, SRC_WAVE, 1'b0);
		for (int k = 0; k < 8; k++)
		begin
			i_cio_far_end.set_lv(1'b0, $random(seed) & 1);
			repeat (6) @(posedge i_clk);
			check(o_out_line_a, wave);
		end
		// Strobe A from trigger: width floor, frame clamp, timing
		wr(OFS_LINE_PICK, LINE_OUT_B, 1'b0);
		wr(OFS_OUTPUT_SIGNAL_CHOICE, SRC_FLASH_A, 1'b0);
		wr(OFS_FLASH_A_ORIGIN, ORG_TRIGGER, 1'b0);
		wr(OFS_FLASH_A_ON, 32'h0000_0001, 1'b0);
		wr(OFS_FLASH_A_OFFSET_US, 32'h0000_0005, 1'b0);
		wr(OFS_FLASH_A_LENGTH_US, 32'h0000_0003, 1'b0);
		rdc(OFS_FLASH_A_LENGTH_US, 32'h0000_000A);
		wr(OFS_FRAME_PERIOD_US, 32'h0000_0014, 1'b0);
		wr(OFS_FLASH_A_LENGTH_US, 32'h0000_03E8, 1'b0);
		rdc(OFS_FLASH_A_LENGTH_US, 32'h0000_000F);
		wr(OFS_FRAME_PERIOD_US, FRAME_PERIOD_RST, 1'b0);
		wr(OFS_FLASH_A_LENGTH_US, 32'h0000_000A, 1'b0);
		fork
			i_cio_far_end.trig(4);
			meas();
		join
		check(d >= 400 && d <= 620, 1'b1);
		check(w >= 890 && w <= 1110, 1'b1);
		wr(OFS_FLASH_A_ON, 32'h0000_0000, 1'b0);
		fork
			i_cio_far_end.trig(4);
			meas();
		join
		check(w, 32'h0000_0000);
		check(n_trig, 32'h0000_0002);
		// Strobe B alone, from integration begin with no delay
		wr(OFS_OUTPUT_SIGNAL_CHOICE, SRC_FLASH_B, 1'b0);
		wr(OFS_FLASH_B_ORIGIN, ORG_INT_BEGIN, 1'b0);
		wr(OFS_FLASH_B_ON, 32'h0000_0001, 1'b0);
		wr(OFS_FLASH_B_OFFSET_US, 32'h0000_0000, 1'b0);
		wr(OFS_FLASH_B_LENGTH_US, 32'h0000_000A, 1'b0);
		fork
			i_cio_far_end.expose(50);
			meas();
		join
		check(d <= 220, 1'b1);
		check(w >= 890 && w <= 1110, 1'b1);
		// Same strobe from the readout edge, fifty clocks after exposure begins
		wr(OFS_FLASH_B_ORIGIN, ORG_READOUT, 1'b0);
		fork
			i_cio_far_end.expose(50);
			meas();
		join
		check(d >= 50 && d <= 70, 1'b1);
		check(w >= 890 && w <= 1110, 1'b1);
		stop_test();
	end
endmodule
